// *** design/tmw_pkg.sv ***
// shared constants for the compare/capture timer block
`default_nettype none
package tmw_pkg;
    // bus widths, counter width and channel count
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int NUM_CH = 4;
    // register byte offsets
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_COUNT = 8'h08;
    localparam logic [7:0] OFF_GR_FIRST = 8'h0C;
    localparam logic [7:0] OFF_GR_SECOND = 8'h10;
    localparam logic [7:0] OFF_GR_THIRD = 8'h14;
    localparam logic [7:0] OFF_GR_FOURTH = 8'h18;
    localparam logic [7:0] OFF_PIN_DIR = 8'h1C;
    // mode register fields
    localparam int MODE_RUN = 7;
    localparam int MODE_RSVD_HI = 6;
    localparam int MODE_BUF_B = 5;
    localparam int MODE_BUF_A = 4;
    localparam int MODE_RSVD_LO = 3;
    localparam int MODE_PWM_D = 2;
    localparam int MODE_PWM_C = 1;
    localparam int MODE_PWM_B = 0;
    localparam logic [7:0] MODE_RSVD_MASK = 8'h48;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // control register fields
    localparam int CTRL_CLR = 7;
    localparam int CTRL_CKS_HI = 6;
    localparam int CTRL_CKS_LO = 4;
    localparam int CTRL_LVL_HI = 3;
    localparam int CTRL_LVL_LO = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // clock select codes
    localparam logic [2:0] CKS_DIV1 = 3'h0;
    localparam logic [2:0] CKS_DIV2 = 3'h1;
    localparam logic [2:0] CKS_DIV4 = 3'h2;
    localparam logic [2:0] CKS_DIV8 = 3'h3;
    // other reset values
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] GR_RESET = 16'hFFFF;
    localparam logic [3:0] PIN_DIR_RESET = 4'h0;
    // channel indices
    localparam int CH_A = 0;
    localparam int CH_B = 1;
    localparam int CH_C = 2;
    localparam int CH_D = 3;
endpackage : tmw_pkg
`default_nettype wire

// *** design/tmw_top.sv ***
// compare/capture timer: mode, control, counter and general registers
// Notes on behaviour
// RL1 - counter holds while run bit is 0, advances on count clock when 1
// RL2 - buffer select B makes fourth register the buffer of the second
// RL3 - buffer select A makes third register the buffer of the first
// RL4 - pulse width mode D turns pin D into a PWM output
// RL5 - pulse width mode C turns pin C into a PWM output
// RL6 - pulse width mode B turns pin B into a PWM output
// RL7 - clear bit set resets counter on match A, else free running
// RL8 - clock select 000..011 picks system clock divided by 1, 2, 4, 8
// RL9 - clock select top bit 1 counts rising edges of the external event
// RL10 - undivided clock selected in sub-clock state counts sub-clock ticks
// RL11 - level bit D drives pin D until first match D
// RL12 - level bit C drives pin C until first match C
// RL13 - level bit B drives pin B until first match B
// RL14 - level bit A drives pin A until first match A
// RL15 - writing a level bit changes the pin at once
// RL16 - mode register bits 6 and 3 always read as 1
// RL17 - pin A is compare output or capture input, never PWM
// RL18 - pins B, C, D are compare, capture, or PWM outputs
// RL19 - external event is synchronised and edge detected on pclk
// RL20 - mode and control bits reset to zero
`default_nettype none
module tmw_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [tmw_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tmw_pkg::DATA_W-1:0] pwdata,
    output logic [tmw_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // count sources
    input wire logic external_event_input,
    input wire logic sub_clock_active,
    input wire logic sub_clock_tick,
    // channel pins
    input wire logic channel_pin_a_in,
    output logic channel_pin_a_out,
    output logic channel_pin_a_oe,
    input wire logic channel_pin_b_in,
    output logic channel_pin_b_out,
    output logic channel_pin_b_oe,
    input wire logic channel_pin_c_in,
    output logic channel_pin_c_out,
    output logic channel_pin_c_oe,
    input wire logic channel_pin_d_in,
    output logic channel_pin_d_out,
    output logic channel_pin_d_oe
);
    import tmw_pkg::*;

    logic [7:0] timer_mode_select;
    logic [7:0] timer_control_select;
    logic [CNT_W-1:0] count_value;
    logic [CNT_W-1:0] gr [NUM_CH];
    logic [NUM_CH-1:0] pin_dir;
    logic [NUM_CH-1:0] pin_level;
    logic [NUM_CH-1:0] pin_prev;
    logic [NUM_CH-1:0] pin_in;
    logic [NUM_CH-1:0] match;
    logic [NUM_CH-1:0] capture;
    logic [NUM_CH-1:0] gr_wr;
    logic [2:0] prescale;
    logic event_meta;
    logic event_sync;
    logic event_prev;
    logic event_rise;
    logic count_tick;
    logic count_step;
    logic access;
    logic bus_write;
    logic [DATA_W-1:0] next_prdata;
    logic next_pslverr;

    // field views
    logic run;
    logic buffer_select_a;
    logic buffer_select_b;
    logic [NUM_CH-1:0] pwm_mode;
    logic clear_on_match_a;
    logic [2:0] clock_select;

    assign run = timer_mode_select[MODE_RUN];
    assign buffer_select_a = timer_mode_select[MODE_BUF_A];
    assign buffer_select_b = timer_mode_select[MODE_BUF_B];
    // pin A has no PWM role [RL17]
    assign pwm_mode = {timer_mode_select[MODE_PWM_D],
                       timer_mode_select[MODE_PWM_C],
                       timer_mode_select[MODE_PWM_B], 1'b0};
    assign clear_on_match_a = timer_control_select[CTRL_CLR];
    assign clock_select = timer_control_select[CTRL_CKS_HI:CTRL_CKS_LO];
    assign pin_in = {channel_pin_d_in, channel_pin_c_in,
                     channel_pin_b_in, channel_pin_a_in};

    // register address check, shared by read and write paths
    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [7:0] off);
        addr_is = (a == off);
    endfunction : addr_is

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = addr_is(a, OFF_MODE) || addr_is(a, OFF_CTRL) ||
                      addr_is(a, OFF_COUNT) || addr_is(a, OFF_GR_FIRST) ||
                      addr_is(a, OFF_GR_SECOND) ||
                      addr_is(a, OFF_GR_THIRD) ||
                      addr_is(a, OFF_GR_FOURTH) ||
                      addr_is(a, OFF_PIN_DIR);
    endfunction : addr_mapped

    // apb: one wait state, write lands on the edge with pready high
    assign access = psel && penable;
    assign bus_write = access && pready && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access && !pready;
        end
    end

    always_comb begin
        next_prdata = '0;
        next_pslverr = !addr_mapped(paddr);
        if (addr_is(paddr, OFF_MODE)) begin
            next_prdata[7:0] = timer_mode_select | MODE_RSVD_MASK; // [RL16]
        end else if (addr_is(paddr, OFF_CTRL)) begin
            next_prdata[7:0] = timer_control_select;
        end else if (addr_is(paddr, OFF_COUNT)) begin
            next_prdata[CNT_W-1:0] = count_value;
        end else if (addr_is(paddr, OFF_GR_FIRST)) begin
            next_prdata[CNT_W-1:0] = gr[CH_A];
        end else if (addr_is(paddr, OFF_GR_SECOND)) begin
            next_prdata[CNT_W-1:0] = gr[CH_B];
        end else if (addr_is(paddr, OFF_GR_THIRD)) begin
            next_prdata[CNT_W-1:0] = gr[CH_C];
        end else if (addr_is(paddr, OFF_GR_FOURTH)) begin
            next_prdata[CNT_W-1:0] = gr[CH_D];
        end else if (addr_is(paddr, OFF_PIN_DIR)) begin
            next_prdata[NUM_CH-1:0] = pin_dir;
        end
    end

    // read data changes only as the answer is given; error is set then and cleared on the next cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            prdata <= pwrite ? '0 : next_prdata;
            pslverr <= next_pslverr;
        end else begin
            pslverr <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_mode_select <= MODE_RESET; // [RL20]
            timer_control_select <= CTRL_RESET; // [RL20]
            pin_dir <= PIN_DIR_RESET;
        end else if (bus_write) begin
            if (addr_is(paddr, OFF_MODE)) begin
                timer_mode_select <= pwdata[7:0] & ~MODE_RSVD_MASK;
            end
            if (addr_is(paddr, OFF_CTRL)) begin
                timer_control_select <= pwdata[7:0];
            end
            if (addr_is(paddr, OFF_PIN_DIR)) begin
                pin_dir <= pwdata[NUM_CH-1:0];
            end
        end
    end

    // external event: two flops, then edge detect on the settled copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_meta <= 1'b0;
            event_sync <= 1'b0;
            event_prev <= 1'b0;
        end else begin
            event_meta <= external_event_input; // [RL19]
            event_sync <= event_meta;
            event_prev <= event_sync;
        end
    end
    assign event_rise = event_sync && !event_prev; // [RL19]

    // free running prescaler keeps divided ticks phase stable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= 3'h0;
        end else begin
            prescale <= prescale + 3'h1;
        end
    end

    always_comb begin
        case (clock_select)
            CKS_DIV1: begin
                // low-speed state counts the sub-clock instead [RL10]
                count_tick = sub_clock_active ? sub_clock_tick : 1'b1;
            end
            CKS_DIV2: count_tick = prescale[0]; // [RL8]
            CKS_DIV4: count_tick = &prescale[1:0]; // [RL8]
            CKS_DIV8: count_tick = &prescale[2:0]; // [RL8]
            default: count_tick = event_rise; // [RL9]
        endcase
    end
    assign count_step = run && count_tick; // [RL1]

    // compares and captures; buffer registers take no part of their own
    generate
        for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
            logic buffered;
            if (i == CH_C) begin : g_c
                assign buffered = buffer_select_a; // [RL3]
            end else if (i == CH_D) begin : g_d
                assign buffered = buffer_select_b; // [RL2]
            end else begin : g_ab
                assign buffered = 1'b0;
            end
            assign match[i] = count_step && !pin_dir[i] && !buffered &&
                              (count_value == gr[i]);
            assign capture[i] = pin_dir[i] && !buffered &&
                                pin_in[i] && !pin_prev[i];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev <= '0;
        end else begin
            pin_prev <= pin_in;
        end
    end

    // counter: software write wins over counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value <= COUNT_RESET;
        end else if (bus_write && addr_is(paddr, OFF_COUNT)) begin
            count_value <= pwdata[CNT_W-1:0];
        end else if (count_step) begin // [RL1]
            if (clear_on_match_a && match[CH_A]) begin
                count_value <= COUNT_RESET; // [RL7]
            end else begin
                count_value <= count_value + 16'h0001; // [RL7]
            end
        end
    end

    assign gr_wr[CH_A] = bus_write && addr_is(paddr, OFF_GR_FIRST);
    assign gr_wr[CH_B] = bus_write && addr_is(paddr, OFF_GR_SECOND);
    assign gr_wr[CH_C] = bus_write && addr_is(paddr, OFF_GR_THIRD);
    assign gr_wr[CH_D] = bus_write && addr_is(paddr, OFF_GR_FOURTH);

    // general registers; buffer moves on match or capture of its partner
    generate
        for (genvar p = 0; p < 2; p++) begin : g_pair
            logic pair_buf;
            assign pair_buf = (p == 0) ? buffer_select_a : buffer_select_b;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    gr[p] <= GR_RESET;
                    gr[p+2] <= GR_RESET;
                end else begin
                    if (gr_wr[p]) begin
                        gr[p] <= pwdata[CNT_W-1:0];
                    end else if (capture[p]) begin
                        gr[p] <= count_value;
                    end else if (pair_buf && match[p]) begin
                        gr[p] <= gr[p+2]; // [RL2] [RL3]
                    end
                    if (gr_wr[p+2]) begin
                        gr[p+2] <= pwdata[CNT_W-1:0];
                    end else if (pair_buf && capture[p]) begin
                        gr[p+2] <= gr[p]; // [RL2] [RL3]
                    end else if (capture[p+2]) begin
                        gr[p+2] <= count_value;
                    end
                end
            end
        end
    endgenerate

    // pin levels; a control write sets them at once, ahead of a match
    generate
        for (genvar i = 0; i < NUM_CH; i++) begin : g_pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_level[i] <= 1'b0;
                end else if (bus_write && addr_is(paddr, OFF_CTRL)) begin
                    // [RL11] [RL12] [RL13] [RL14] [RL15]
                    pin_level[i] <= pwdata[CTRL_LVL_LO+i];
                end else if (pwm_mode[i]) begin
                    // period ends on match A, duty ends on own match
                    if (match[i]) begin
                        pin_level[i] <= 1'b0; // [RL4] [RL5] [RL6]
                    end else if (match[CH_A]) begin
                        pin_level[i] <= 1'b1; // [RL18]
                    end
                end else if (match[i]) begin
                    pin_level[i] <= !pin_level[i]; // [RL17] [RL18]
                end
            end
        end
    endgenerate

    // pin drivers from flops; a capture input releases its pin unless PWM mode is set on it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_pin_a_out <= 1'b0;
            channel_pin_b_out <= 1'b0;
            channel_pin_c_out <= 1'b0;
            channel_pin_d_out <= 1'b0;
            channel_pin_a_oe <= 1'b0;
            channel_pin_b_oe <= 1'b0;
            channel_pin_c_oe <= 1'b0;
            channel_pin_d_oe <= 1'b0;
        end else begin
            channel_pin_a_out <= pin_level[CH_A];
            channel_pin_b_out <= pin_level[CH_B];
            channel_pin_c_out <= pin_level[CH_C];
            channel_pin_d_out <= pin_level[CH_D];
            channel_pin_a_oe <= !pin_dir[CH_A]; // [RL17]
            channel_pin_b_oe <= !pin_dir[CH_B] || pwm_mode[CH_B]; // [RL18]
            channel_pin_c_oe <= !pin_dir[CH_C] || pwm_mode[CH_C];
            channel_pin_d_oe <= !pin_dir[CH_D] || pwm_mode[CH_D];
        end
    end
endmodule : tmw_top
`default_nettype wire

// *** test/tmw_chk.sv ***
// assertions on the timer's bus and pin ports
`default_nettype none
module tmw_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic [tmw_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tmw_pkg::DATA_W-1:0] pwdata,
    input wire logic [tmw_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic channel_pin_a_out,
    input wire logic channel_pin_b_out,
    input wire logic channel_pin_c_out,
    input wire logic channel_pin_d_out
);
    import tmw_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // levels only checked while stopped: a match may follow a write
    logic run_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
        end else if (psel && penable && pready && pwrite
                     && paddr == OFF_MODE) begin
            run_q <= pwdata[MODE_RUN];
        end
    end
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_ctrl_wr;
        psel && penable && pready && pwrite && paddr == OFF_CTRL && !run_q;
    endsequence
    a_ready_wait:
        assert property (s_access |=> pready) else $error("pready late");
    a_ready_pulse:
        assert property (pready |=> !pready) else $error("pready held");
    a_err_unmapped:
        assert property (pready && paddr > OFF_PIN_DIR |-> pslverr)
        else $error("no error on unmapped");
    a_rsvd_ones:
        assert property (pready && !pwrite && paddr == OFF_MODE
            |-> prdata[6] && prdata[3]) else $error("reserved bit low");
    a_level_a:
        assert property (s_ctrl_wr |-> ##2
            channel_pin_a_out == $past(pwdata[0], 2)) else $error("pin a");
    a_level_b:
        assert property (s_ctrl_wr |-> ##2
            channel_pin_b_out == $past(pwdata[1], 2)) else $error("pin b");
    a_level_c:
        assert property (s_ctrl_wr |-> ##2
            channel_pin_c_out == $past(pwdata[2], 2)) else $error("pin c");
    a_level_d:
        assert property (s_ctrl_wr |-> ##2
            channel_pin_d_out == $past(pwdata[3], 2)) else $error("pin d");
endmodule : tmw_chk
bind tmw_top tmw_chk u_chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_pin_a_out(channel_pin_a_out),
    .channel_pin_b_out(channel_pin_b_out),
    .channel_pin_c_out(channel_pin_c_out),
    .channel_pin_d_out(channel_pin_d_out)
);
`default_nettype wire

// *** test/tmw_far.sv ***
// far side model: event source, sub-clock ticks and pin loads
`default_nettype none
module tmw_far (
    // clock and settings
    input wire logic pclk,
    input wire logic [7:0] ev_half,
    input wire logic [7:0] sub_per,
    // pin loads
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    output logic [3:0] pin_in,
    // count sources
    output logic ext_ev,
    output logic sub_tick
);
    logic [7:0] ev_cnt = 8'h00;
    logic [7:0] sub_cnt = 8'h00;
    initial begin
        ext_ev = 1'b0;
        sub_tick = 1'b0;
    end
    // event toggles every ev_half cycles, so rises every 2*ev_half
    always @(posedge pclk) begin
        ev_cnt <= (ev_cnt + 8'h01 >= ev_half) ? 8'h00 : ev_cnt + 8'h01;
        if (ev_cnt + 8'h01 >= ev_half) begin
            ext_ev <= ~ext_ev;
        end
        sub_cnt <= (sub_cnt + 8'h01 >= sub_per) ? 8'h00 : sub_cnt + 8'h01;
        sub_tick <= (sub_cnt + 8'h01 >= sub_per);
    end
    // no pull on the pins: a released pin shows the inverse drive
    assign pin_in = ~(pin_oe ^ pin_out);
endmodule : tmw_far
`default_nettype wire

// *** test/tmw_top_tb.sv ***
// self-checking bench for the timer mode and control block
`default_nettype none
module tmw_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tmw_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sub_active = 1'b0;
    logic [7:0] ev_half = 8'h03;
    logic [7:0] sub_per = 8'h07;
    logic [3:0] v;
    wire logic ext_ev;
    wire logic sub_tick;
    wire logic [3:0] pin_in;
    wire logic [3:0] pin_out;
    wire logic [3:0] pin_oe;
    logic [32:0] notes[$];
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int p;
    int q;
    int n;
    int exp_n;
    always #2.5 pclk = ~pclk;
    tmw_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_event_input(ext_ev), .sub_clock_active(sub_active),
        .sub_clock_tick(sub_tick), .channel_pin_a_in(pin_in[0]),
        .channel_pin_a_out(pin_out[0]), .channel_pin_a_oe(pin_oe[0]),
        .channel_pin_b_in(pin_in[1]), .channel_pin_b_out(pin_out[1]),
        .channel_pin_b_oe(pin_oe[1]), .channel_pin_c_in(pin_in[2]),
        .channel_pin_c_out(pin_out[2]), .channel_pin_c_oe(pin_oe[2]),
        .channel_pin_d_in(pin_in[3]), .channel_pin_d_out(pin_out[3]),
        .channel_pin_d_oe(pin_oe[3]));
    tmw_far far (.pclk(pclk), .ev_half(ev_half), .sub_per(sub_per),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
        .ext_ev(ext_ev), .sub_tick(sub_tick));
    task automatic stop_test();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // e notes {pslverr, read data}; writes note zero data
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        notes.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait limit of its own: only the cycle ceiling ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : bus
    task automatic wr(input logic [7:0] a, input int d);
        bus(1'b1, a, 32'(d), 33'h0);
    endtask : wr
    task automatic run(input logic [7:0] ctrl, input logic [7:0] mode);
        wr(OFF_MODE, 0);
        wr(OFF_COUNT, 0);
        wr(OFF_CTRL, ctrl);
        wr(OFF_MODE, mode);
    endtask : run
    // high time of a pin in cycles, from a fresh rising edge
    task automatic width(input int ch, output int w);
        int k;
        k = 0;
        w = 0;
        while (pin_out[ch] !== 1'b0 && k < 3000) begin
            @(posedge pclk);
            k++;
        end
        while (pin_out[ch] !== 1'b1 && k < 3000) begin
            @(posedge pclk);
            k++;
        end
        while (pin_out[ch] === 1'b1 && w < 3000) begin
            @(posedge pclk);
            w++;
        end
    endtask : width
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (notes.size() == 0) begin
                num_errors++;
            end else begin
                chk({pslverr, pwrite ? 32'h0 : prdata}, notes.pop_front());
            end
        end
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(32'h999f));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        bus(1'b0, OFF_MODE, 0, 33'h48);
        bus(1'b0, OFF_CTRL, 0, 33'h0);
        bus(1'b0, OFF_GR_FIRST, 0, 33'hFFFF);
        bus(1'b0, 8'h20, 0, 33'h100000000);
        bus(1'b1, 8'h24, 5, 33'h100000000);
        chk(33'(pin_oe), 33'hF);
        wr(OFF_MODE, 8'h37);
        bus(1'b0, OFF_MODE, 0, 33'h7F);
        wr(OFF_MODE, 0);
        // stopped counter keeps a written value
        wr(OFF_COUNT, 16'h1234);
        repeat (20) @(posedge pclk);
        bus(1'b0, OFF_COUNT, 0, 33'h1234);
        // capture on a and b: releasing the pins makes them rise
        wr(OFF_CTRL, 0);
        wr(OFF_GR_FIRST, 16'h1111);
        wr(OFF_GR_SECOND, 16'h2222);
        wr(OFF_MODE, 8'h30);
        wr(OFF_PIN_DIR, 4'h3);
        bus(1'b0, OFF_GR_FIRST, 0, 33'h1234);
        bus(1'b0, OFF_GR_THIRD, 0, 33'h1111);
        bus(1'b0, OFF_GR_SECOND, 0, 33'h1234);
        bus(1'b0, OFF_GR_FOURTH, 0, 33'h2222);
        chk(33'(pin_oe), 33'hC);
        wr(OFF_PIN_DIR, 0);
        wr(OFF_MODE, 0);
        repeat (4) begin
            v = 4'($urandom);
            wr(OFF_CTRL, v);
            @(posedge pclk);
            chk(33'(pin_out), 33'(v));
        end
        // pin a toggle period for every clock select code
        p = 3 + $urandom % 6;
        wr(OFF_GR_FIRST, p);
        for (int c = 0; c < 8; c++) begin
            run({1'b1, c[2:0], 4'h0}, 8'h80);
            width(0, n);
            exp_n = c < 4 ? (p + 1) << c : (p + 1) * 2 * ev_half;
            chk(33'(n), 33'(exp_n));
        end
        // clear bit off: counter runs past match a, 52 steps to the read
        run(8'h00, 8'h80);
        repeat (50) @(posedge pclk);
        bus(1'b0, OFF_COUNT, 0, 33'h34);
        sub_active <= 1'b1;
        run(8'h80, 8'h80);
        width(0, n);
        chk(33'(n), 33'((p + 1) * sub_per));
        sub_active <= 1'b0;
        // pwm on b..d: set on match a, cleared on own match
        q = $urandom % p;
        wr(OFF_GR_SECOND, q);
        wr(OFF_GR_THIRD, q);
        wr(OFF_GR_FOURTH, q);
        run(8'h80, 8'h87);
        for (int ch = 0; ch < 4; ch++) begin
            width(ch, n);
            // pin a stays a toggling compare output
            exp_n = ch == 0 ? p + 1 : q + 1;
            chk(33'(n), 33'(exp_n));
        end
        stop_test();
    end
endmodule : tmw_top_tb
`default_nettype wire
